// File: core/ccr_control_regs.sv
`timescale 1ns/1ps
`default_nettype none

module ccr_control_regs
    import ccr_pkg::*;
#(
    // Cascade size up to which the duty rule looks at FIR bypass
    parameter int CASCADE_LIMIT = 4,
    // Largest cascade that the three-bit device address can name
    parameter int CASCADE_MAX   = 8
)
(
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    // Cascade position from cascade detection
    input  wire logic [2:0] cascade_addr_i,
    input  wire logic [2:0] cascade_count_i,
    // Control word from serial port logic
    input  wire ccr_word_t  ctrl_word_i,
    // Path status
    input  wire logic       fir_overflow_i,
    input  wire logic       secondary_comm_i,
    // Outputs
    output ccr_ctrl_t       ctrl_o,
    output logic            soft_reset_o,
    output logic            flag_o,
    output logic            read_valid_o,
    output logic [15:0]     read_word_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  path;
        logic [7:0]  pwr;
        logic [7:0]  test;
        logic [7:0]  gain;
        logic        ovf;
        logic        srst;
        logic        rd_valid;
        logic [15:0] rd_word;
    } ccr_state_t;

    ccr_state_t state_reg;
    ccr_state_t state_next;

    logic [2:0] dev_addr;
    logic       is_master;
    logic       addr_hit;
    logic       wr_req;
    logic       rd_req;
    logic [3:0] reg_addr;
    logic [7:0] payload;
    logic [7:0] path_view;
    logic [5:0] div_n;

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    // The device address field is three bits, so no larger cascade exists
    if (CASCADE_MAX < 1 || CASCADE_MAX > 8) begin : g_bad_max
        $error("CASCADE_MAX must lie between 1 and 8");
    end
    if (CASCADE_LIMIT < 1 || CASCADE_LIMIT >= CASCADE_MAX) begin : g_bad_lim
        $error("CASCADE_LIMIT must lie below CASCADE_MAX");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Fields of a received control word
    function automatic logic [2:0] word_dev(input logic [15:0] w);
        return w[DEV_ADDR_HI:DEV_ADDR_LO];
    endfunction

    function automatic logic [3:0] word_reg(input logic [15:0] w);
        return w[REG_ADDR_HI:REG_ADDR_LO];
    endfunction

    function automatic logic word_is_read(input logic [15:0] w);
        return w[RW_BIT];
    endfunction

    // Overflow is status only and the reset bit never sticks
    function automatic logic [7:0] path_store(input logic [7:0] d);
        logic [7:0] s;
        s = d;
        s[PATH_OVF_BIT] = 1'b0;
        s[PATH_SWRST_BIT] = 1'b0;
        return s;
    endfunction

    // Reserved bit is kept at zero so reads never show junk
    function automatic logic [7:0] pwr_store(input logic [7:0] d);
        logic [7:0] s;
        s = d;
        s[PWR_RSVD_BIT] = 1'b0;
        return s;
    endfunction

    // Divider code 0 stands for the longest divide
    function automatic logic [5:0] div_decode(input logic [4:0] code);
        logic [5:0] n;
        n = {1'b0, code};
        if (code == 5'h00) begin
            n = DIV_ZERO_N;
        end
        return n;
    endfunction

    // Uneven serial clock: long cascade with odd N, or short cascade
    // with FIR bypass and N off a multiple of four
    function automatic logic duty_uneven(input logic [2:0] count,
                                         input logic       fir_byp,
                                         input logic [5:0] n);
        logic u;
        if (int'(count) > CASCADE_LIMIT) begin
            u = n[0];
        end else begin
            u = fir_byp && (n[1:0] != 2'h0);
        end
        return u;
    endfunction

    // Cascade master is the last position; a lone device is its own
    function automatic logic master_of(input logic [2:0] pos,
                                       input logic [2:0] count);
        logic m;
        m = (count == 3'h0) || (pos == count - 3'h1);
        return m;
    endfunction

    // Channel power code to {adc off, dac off, full power-down}
    function automatic logic [2:0] chan_decode(input logic [1:0] code);
        logic [2:0] c;
        c = 3'h0;
        unique case (code)
            CH_ADC_OFF: c = 3'h4;
            CH_DAC_OFF: c = 3'h2;
            CH_PDOWN:   c = 3'h1;
            default:    c = 3'h0;
        endcase
        return c;
    endfunction

    // Register contents after a software reset
    function automatic ccr_state_t soft_cleared(input ccr_state_t s);
        ccr_state_t c;
        c = s;
        c.path = PATH_RESET;
        c.pwr  = PWR_RESET;
        c.test = TEST_RESET;
        c.gain = GAIN_RESET;
        c.ovf  = 1'b0;
        return c;
    endfunction

    function automatic logic [7:0] reg_read(input ccr_state_t s,
                                            input logic [3:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ADDR_PATH: v = {s.ovf, s.path[6:0]};
            ADDR_PWR:  v = s.pwr;
            ADDR_TEST: v = s.test;
            ADDR_GAIN: v = s.gain;
            default:   v = 8'h00;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Word decode
    // ------------------------------------------------------------
    // A lone device sees cascade position 000 from detection
    assign dev_addr  = cascade_addr_i;
    assign is_master = master_of(dev_addr, cascade_count_i);
    assign reg_addr  = word_reg(ctrl_word_i.word);
    assign payload   = ctrl_word_i.word[PAYLOAD_HI:0];
    assign addr_hit  = ctrl_word_i.valid
        && (word_dev(ctrl_word_i.word) == dev_addr);
    // Writes and reads share one decode; only D12 tells them apart
    assign wr_req = addr_hit && !word_is_read(ctrl_word_i.word);
    assign rd_req = addr_hit && word_is_read(ctrl_word_i.word);

    // Next state: word decode, sticky status and the software reset
    always_comb begin
        state_next = state_reg;
        state_next.rd_valid = 1'b0;
        // One-shot reset lasts a single cycle then clears itself
        state_next.srst = 1'b0;
        // Overflow is sticky until the register is read; set wins
        if (rd_req && reg_addr == ADDR_PATH) begin
            state_next.ovf = 1'b0;
        end
        if (fir_overflow_i) begin
            state_next.ovf = 1'b1;
        end
        if (wr_req) begin
            unique case (reg_addr)
                ADDR_PATH: begin
                    state_next.path = path_store(payload);
                    state_next.srst = payload[PATH_SWRST_BIT];
                end
                ADDR_PWR: begin
                    state_next.pwr = pwr_store(payload);
                end
                ADDR_TEST: state_next.test = payload;
                ADDR_GAIN: state_next.gain = payload;
                default: ;
            endcase
        end
        if (rd_req) begin
            state_next.rd_valid = 1'b1;
            state_next.rd_word  = {ctrl_word_i.word[15:8],
                                   reg_read(state_reg, reg_addr)};
        end
        // Software reset returns every register to its default
        if (state_reg.srst) begin
            state_next = soft_cleared(state_next);
        end
    end

    // Synchronous reset clears every register; no clock enable is used
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    assign path_view = state_reg.path;
    assign div_n = div_decode(state_reg.pwr[PWR_DIV_HI:0]);

    always_comb begin
        ctrl_o = '0;
        ctrl_o.receive_amplifier_en = path_view[PATH_RXAMP_BIT];
        // Receive amp forces the auxiliary pair onto the ADC
        ctrl_o.adc_sel_aux = path_view[PATH_AUX_BIT]
                             || path_view[PATH_RXAMP_BIT];
        ctrl_o.aaf_bypass = path_view[PATH_AAF_BIT];
        ctrl_o.fir_bypass = path_view[PATH_FIR_BIT];
        ctrl_o.transmit_amplifier_one_en = path_view[PATH_TXAMP_BIT];
        ctrl_o.transmit_amplifier_two_en = path_view[PATH_TXAMP_BIT];
        ctrl_o.dac_16bit = path_view[PATH_DAC16_BIT];
        ctrl_o.low_power = state_reg.pwr[PWR_LOWP_BIT];
        ctrl_o.sd_mod_stop = state_reg.pwr[PWR_SDSTOP_BIT];
        ctrl_o.sclk_div_n = div_n;
        // Duty warning follows the live cascade size, not a stored copy
        ctrl_o.sclk_duty_uneven = duty_uneven(cascade_count_i,
            path_view[PATH_FIR_BIT], div_n);
        ctrl_o.test_mode =
            ccr_mode_t'(state_reg.test[TEST_MODE_HI:TEST_MODE_LO]);
        // Only the device wired to the host may stream continuously
        ctrl_o.continuous_xfer = state_reg.test[TEST_CONT_BIT]
                                 && is_master;
        ctrl_o.adc_16bit = state_reg.test[TEST_ADC16_BIT];
        {ctrl_o.adc_disable, ctrl_o.dac_disable, ctrl_o.power_down} =
            chan_decode(state_reg.test[TEST_CH_HI:TEST_CH_LO]);
        ctrl_o.adc_gain = state_reg.gain[7:4];
        ctrl_o.dac_gain = state_reg.gain[3:0];
    end

    // Flag shows the stored value or the secondary flag from the port
    assign flag_o = state_reg.test[TEST_FSEL_BIT]
                    ? state_reg.test[TEST_FVAL_BIT]
                    : secondary_comm_i;
    assign soft_reset_o = state_reg.srst;
    // Read answers come from flip-flops, one cycle after the word
    assign read_valid_o = state_reg.rd_valid;
    assign read_word_o  = state_reg.rd_word;

endmodule

`default_nettype wire

// File: core/ccr_pkg.sv
package ccr_pkg;

    // ------------------------------------------------------------
    // Control word layout
    // ------------------------------------------------------------
    localparam int DEV_ADDR_HI  = 15;
    localparam int DEV_ADDR_LO  = 13;
    localparam int RW_BIT       = 12;
    localparam int REG_ADDR_HI  = 11;
    localparam int REG_ADDR_LO  = 8;
    localparam int PAYLOAD_HI   = 7;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_NOP  = 4'h0;
    localparam logic [3:0] ADDR_PATH = 4'h1;
    localparam logic [3:0] ADDR_PWR  = 4'h2;
    localparam logic [3:0] ADDR_TEST = 4'h3;
    localparam logic [3:0] ADDR_GAIN = 4'h4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PATH_RESET = 8'h00;
    localparam logic [7:0] PWR_RESET  = 8'h00;
    localparam logic [7:0] TEST_RESET = 8'h00;
    localparam logic [7:0] GAIN_RESET = 8'h00;
    localparam logic [2:0] STANDALONE_ADDR = 3'h0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PATH_OVF_BIT   = 7;
    localparam int PATH_RXAMP_BIT = 6;
    localparam int PATH_AAF_BIT   = 5;
    localparam int PATH_AUX_BIT   = 4;
    localparam int PATH_SWRST_BIT = 3;
    localparam int PATH_FIR_BIT   = 2;
    localparam int PATH_TXAMP_BIT = 1;
    localparam int PATH_DAC16_BIT = 0;
    localparam int PWR_LOWP_BIT   = 7;
    localparam int PWR_SDSTOP_BIT = 6;
    localparam int PWR_RSVD_BIT   = 5;
    localparam int PWR_DIV_HI     = 4;
    localparam int TEST_MODE_HI   = 7;
    localparam int TEST_MODE_LO   = 6;
    localparam int TEST_CONT_BIT  = 5;
    localparam int TEST_FSEL_BIT  = 4;
    localparam int TEST_FVAL_BIT  = 3;
    localparam int TEST_CH_HI     = 2;
    localparam int TEST_CH_LO     = 1;
    localparam int TEST_ADC16_BIT = 0;

    localparam logic [5:0] DIV_ZERO_N = 6'h20;
    localparam logic [1:0] CH_ADC_OFF = 2'h1;
    localparam logic [1:0] CH_DAC_OFF = 2'h2;
    localparam logic [1:0] CH_PDOWN   = 2'h3;

    typedef enum logic [1:0] {
        MODE_NORMAL, MODE_ANALOG_LB, MODE_DIGITAL_LB, MODE_EVENT_MON
    } ccr_mode_t;

    // Control word from the serial port
    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } ccr_word_t;

    // Decoded controls for the analog and digital paths
    typedef struct packed {
        logic      receive_amplifier_en;
        logic      transmit_amplifier_one_en;
        logic      transmit_amplifier_two_en;
        logic      adc_sel_aux;
        logic      aaf_bypass;
        logic      fir_bypass;
        logic      dac_16bit;
        logic      adc_16bit;
        logic      low_power;
        logic      sd_mod_stop;
        logic [5:0] sclk_div_n;
        logic      sclk_duty_uneven;
        ccr_mode_t test_mode;
        logic      continuous_xfer;
        logic      adc_disable;
        logic      dac_disable;
        logic      power_down;
        logic [3:0] adc_gain;
        logic [3:0] dac_gain;
    } ccr_ctrl_t;

endpackage

// File: verification/ccr_checker.sv
`timescale 1ns/1ps
`default_nettype none

module ccr_checker
    import ccr_pkg::*;
(
    // Inputs of the block
    input wire logic        core_clk_i,
    input wire logic        reset_i,
    input wire logic [2:0]  cascade_addr_i,
    input wire ccr_word_t   ctrl_word_i,
    // Outputs of the block
    input wire ccr_ctrl_t   ctrl_o,
    input wire logic        soft_reset_o,
    input wire logic        flag_o,
    input wire logic        read_valid_o,
    input wire logic [15:0] read_word_o
);
    logic [15:0] w;
    logic [15:0] w_q;
    logic        hit;
    logic        wr;
    assign w   = ctrl_word_i.word;
    assign hit = ctrl_word_i.valid && w[15:13] == cascade_addr_i;
    // A write in the reset pulse cycle is lost to the clear
    assign wr  = hit && !w[12] && !soft_reset_o;
    always_ff @(posedge core_clk_i) w_q <= w;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    rx_aux_route_a: assert property (ctrl_o.receive_amplifier_en
        |-> ctrl_o.adc_sel_aux) else $error("aux route missing");
    path_write_a: assert property (wr && w[11:8] == ADDR_PATH |=>
        ctrl_o.fir_bypass == w_q[2] && ctrl_o.aaf_bypass == w_q[5]
        && ctrl_o.adc_sel_aux == (w_q[4] | w_q[6])) else $error("path bad");
    amp_format_a: assert property (wr && w[11:8] == ADDR_PATH |=>
        ctrl_o.transmit_amplifier_one_en == w_q[1]
        && ctrl_o.dac_16bit == w_q[0]) else $error("amp or format bad");
    soft_pulse_a: assert property (wr && w[11:8] == ADDR_PATH && w[3]
        |=> soft_reset_o ##1 !soft_reset_o) else $error("reset pulse bad");
    div_code_a: assert property (wr && w[11:8] == ADDR_PWR |=>
        ctrl_o.sclk_div_n == (w_q[4:0] == 5'h00 ? DIV_ZERO_N
        : {1'b0, w_q[4:0]})) else $error("divider bad");
    pwr_mode_a: assert property (wr && w[11:8] == ADDR_PWR |=>
        ctrl_o.low_power == w_q[7] && ctrl_o.sd_mod_stop == w_q[6])
        else $error("power mode bad");
    test_mode_a: assert property (wr && w[11:8] == ADDR_TEST |=>
        ctrl_o.test_mode == w_q[7:6] && ctrl_o.adc_16bit == w_q[0])
        else $error("test mode bad");
    chan_power_a: assert property (wr && w[11:8] == ADDR_TEST |=>
        ctrl_o.power_down == (w_q[2:1] == CH_PDOWN) && (w_q[2:1] == CH_PDOWN
        || ctrl_o.dac_disable == (w_q[2:1] == CH_DAC_OFF)))
        else $error("channel power bad");
    flag_sel_a: assert property (wr && w[11:8] == ADDR_TEST && w[4]
        |=> flag_o == w_q[3]) else $error("flag bad");
    foreign_addr_a: assert property (ctrl_word_i.valid && !hit
        |=> !read_valid_o) else $error("foreign word answered");
    read_echo_a: assert property (hit && w[12] |=> read_valid_o
        && read_word_o[15:8] == w_q[15:8]) else $error("read echo bad");

    cover property (wr && w[11:8] == ADDR_PATH && w[3]);
    cover property (read_valid_o);
    cover property (ctrl_o.sclk_duty_uneven);
endmodule

bind ccr_control_regs ccr_checker i_ccr_checker (
    .core_clk_i(core_clk_i), .reset_i(reset_i),
    .cascade_addr_i(cascade_addr_i), .ctrl_word_i(ctrl_word_i),
    .ctrl_o(ctrl_o), .soft_reset_o(soft_reset_o), .flag_o(flag_o),
    .read_valid_o(read_valid_o), .read_word_o(read_word_o)
);

`default_nettype wire

// File: verification/ccr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module ccr_host_model
    import ccr_pkg::*;
(
    // Clock
    input  wire logic     core_clk_i,
    // Control word towards the device
    output var ccr_word_t ctrl_word_o
);
    initial ctrl_word_o = '{valid: 1'b0, word: 16'h0000};

    // Released word shows its inverse so a stale value cannot pass
    task automatic send(input logic [15:0] w);
        @(posedge core_clk_i);
        ctrl_word_o <= '{valid: 1'b1, word: w};
        @(posedge core_clk_i);
        ctrl_word_o <= '{valid: 1'b0, word: ~w};
    endtask
endmodule

`default_nettype wire

// File: verification/codec_control_register_set_test.sv
`timescale 1ns/1ps
`default_nettype none

module codec_control_register_set_test;
    import ccr_pkg::*;
    typedef struct packed {logic [15:0] word; logic [7:0] exp;} ccr_row_t;
    logic        core_clk = 1'b0;
    logic        reset    = 1'b1;
    logic        fir_ovf  = 1'b0;
    logic        sec_comm = 1'b0;
    logic [2:0]  cas_addr = 3'h0;
    logic [2:0]  cas_count = 3'h0;
    ccr_word_t   ctrl_word;
    ccr_ctrl_t   ctrl;
    logic        soft_rst;
    logic        flag;
    logic        rd_valid;
    logic [15:0] rd_word;
    int          n_errors = 0;
    int          total_checks = 0;
    ccr_row_t    rows [9] = '{'{16'h0146, 8'h46}, '{16'h0131, 8'h31},
        '{16'h02ff, 8'hdf}, '{16'h02a0, 8'h80}, '{16'h0241, 8'h41},
        '{16'h04a5, 8'ha5}, '{16'h0341, 8'h41}, '{16'h0382, 8'h82},
        '{16'h03d4, 8'hd4}};

    always #12.5 core_clk = ~core_clk;

    ccr_host_model i_ccr_host_model (.core_clk_i(core_clk),
        .ctrl_word_o(ctrl_word));
    ccr_control_regs i_ccr_control_regs (.core_clk_i(core_clk),
        .reset_i(reset), .cascade_addr_i(cas_addr),
        .cascade_count_i(cas_count),
        .ctrl_word_i(ctrl_word), .fir_overflow_i(fir_ovf),
        .secondary_comm_i(sec_comm), .ctrl_o(ctrl), .soft_reset_o(soft_rst),
        .flag_o(flag), .read_valid_o(rd_valid), .read_word_o(rd_word));

    task automatic chk(input string name, input logic [15:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] w);
        i_ccr_host_model.send(w);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        i_ccr_host_model.send({4'h1, a, 8'h00});
        #1;
        chk("read_valid", 16'h0001, {15'h0, rd_valid});
        chk("read_word", {4'h1, a, exp}, rd_word);
    endtask

    task automatic end_sim;
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Whole run needs well under 5 us
    initial begin
        #100000;
        n_errors++;
        end_sim;
    end

    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        chk("div_n", 16'h0020, {10'h0, ctrl.sclk_div_n});
        for (int a = 1; a < 5; a++) rd(a[3:0], 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].word);
            rd(rows[i].word[11:8], rows[i].exp);
        end
        wr(16'h2155);
        rd(4'h1, 8'h31);
        wr(16'h0077);
        wr(16'h0577);
        rd(4'h1, 8'h31);
        wr(16'h0108);
        #1;
        chk("soft_reset", 16'h0001, {15'h0, soft_rst});
        @(posedge core_clk);
        #1;
        chk("soft_reset", 16'h0000, {15'h0, soft_rst});
        rd(4'h1, 8'h00);
        rd(4'h3, 8'h00);
        @(posedge core_clk) fir_ovf <= 1'b1;
        @(posedge core_clk) fir_ovf <= 1'b0;
        rd(4'h1, 8'h80);
        rd(4'h1, 8'h00);
        @(posedge core_clk) sec_comm <= 1'b1;
        #1;
        chk("flag", 16'h0001, {15'h0, flag});
        wr(16'h0318);
        @(posedge core_clk) sec_comm <= 1'b0;
        #1;
        chk("flag", 16'h0001, {15'h0, flag});
        wr(16'h0104);
        wr(16'h0205);
        #1;
        chk("duty", 16'h0001, {15'h0, ctrl.sclk_duty_uneven});
        wr(16'h0204);
        #1;
        chk("duty", 16'h0000, {15'h0, ctrl.sclk_duty_uneven});
        wr(16'h0320);
        #1;
        chk("cont", 16'h0001, {15'h0, ctrl.continuous_xfer});
        wr(16'h0140);
        #1;
        chk("aux", 16'h0001, {15'h0, ctrl.adc_sel_aux});
        @(posedge core_clk);
        cas_addr  <= 3'h2;
        cas_count <= 3'h4;
        #1;
        chk("cont", 16'h0000, {15'h0, ctrl.continuous_xfer});
        wr(16'h4300);
        cas_addr <= 3'h3;
        wr(16'h6320);
        #1;
        chk("cont", 16'h0001, {15'h0, ctrl.continuous_xfer});
        wr(16'h4300);
        #1;
        chk("cont", 16'h0001, {15'h0, ctrl.continuous_xfer});
        end_sim;
    end
endmodule

`default_nettype wire
